// ### hw/sfd_consts.vh
// Constants for the supply fault detector logic.
`ifndef SFD_CONSTS_VH
`define SFD_CONSTS_VH
`define NUM_CH 8
`define NUM_DUAL 4
`define CH_HV 7
`define CH_VP_LO 4
`define CLK_MHZ 100
`define CYC_PER_US 14'h0064
`define FILT_MAX_US 7'h64
`define OFF_CFG 2'h0
`define OFF_UVTH 2'h1
`define OFF_OVTH 2'h2
`define OFF_FILT 2'h3
`define ADDR_STATUS 8'h80
`define ADDR_IRQ_STAT 8'h84
`define ADDR_IRQ_MASK 8'h88
`define CFG_MODE_LSB 0
`define CFG_RANGE_LSB 2
`define CFG_ANALOG_BIT 4
`define CFG_HYST_LSB 8
`define MODE_OFF 2'h0
`define MODE_UV 2'h1
`define MODE_OV 2'h2
`define MODE_WIN 2'h3
`define RANGE_LOW 2'h0
`define RANGE_MID 2'h1
`define RANGE_HI 2'h2
`define RANGE_TOP 2'h3
`define CODE_MAX 8'hff
`endif

// ### hw/supply_fault_detector.v
// Digital side of eight supply fault detectors with an APB register file.
`timescale 1ns/10ps
`include "sfd_consts.vh"

// Functional notes
// - Eight channels: 0-3 dual-function, 4-7 always fault detectors.
// - With all dual channels analog, no logic input is enabled.
// - Each detector flags undervoltage, overvoltage, or out-of-window.
// - Thresholds are 8-bit codes; volts are span*N/255 plus bottom.
// - Four ranges: 0.573/0.802, 1.25/1.75, 2.5/3.5, 6.0/8.4 V.
// - High-voltage channel selects 2.5-6.0 V or 6.0-14.4 V range.
// - Positive channels select 0.573-1.375, 1.25-3.00 or 2.5-6.0 V.
// - Undervoltage clears only above threshold plus hysteresis.
// - Overvoltage clears only below threshold minus hysteresis.
// - Hysteresis is a 5-bit code, span*code/255, max 31.
// - Glitch filter is the last stage, after hysteresis.
// - Filter timeout up to 100 us; shorter pulses suppressed.
// - Passed transitions appear delayed by the programmed timeout.
module supply_fault_detector (
  input wire i_clk, // 100 MHz clock
  input wire i_arst_n, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire [7:0] i_uv_below, // Comparator: rail below uv reference
  input wire [7:0] i_ov_above, // Comparator: rail above ov reference
  output wire [63:0] o_uv_ref, // Uv reference codes, 8 bits per channel
  output wire [63:0] o_ov_ref, // Ov reference codes, 8 bits per channel
  output wire [15:0] o_range_sel, // Attenuator range, 2 bits per channel
  output wire [3:0] o_logic_input_en, // Dual channel used as logic input
  output wire [7:0] o_fault, // Filtered fault per channel
  output wire o_irq // Interrupt, active high level
);

  reg [1:0] cfg_mode [0:7];
  reg [1:0] cfg_range [0:7];
  reg [4:0] cfg_hyst [0:7];
  reg [7:0] uvth [0:7];
  reg [7:0] ovth [0:7];
  reg [6:0] filt_us [0:7];
  reg [3:0] dual_analog;
  reg [7:0] irq_stat;
  reg [7:0] irq_mask;
  reg [31:0] rdata;
  reg addr_ok;

  wire [7:0] fault_vec;
  wire [7:0] event_vec;
  wire [7:0] analog_sel;
  wire [2:0] ch;
  wire [1:0] sub;
  wire chan_space;
  wire wr_en;
  wire wr_cfg;
  wire wr_uvth;
  wire wr_ovth;
  wire wr_filt;
  wire wr_stat;
  wire wr_mask;
  wire [1:0] wr_range;
  reg [1:0] next_range;
  reg [6:0] next_filt;
  reg [7:0] next_irq_stat;
  integer k;

  assign ch = paddr[6:4];
  assign sub = paddr[3:2];
  assign chan_space = ~paddr[7] & (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = rdata;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign wr_cfg = wr_en & chan_space & (sub == `OFF_CFG);
  assign wr_uvth = wr_en & chan_space & (sub == `OFF_UVTH);
  assign wr_ovth = wr_en & chan_space & (sub == `OFF_OVTH);
  assign wr_filt = wr_en & chan_space & (sub == `OFF_FILT);
  assign wr_stat = wr_en & (paddr == `ADDR_IRQ_STAT);
  assign wr_mask = wr_en & (paddr == `ADDR_IRQ_MASK);
  assign wr_range = pwdata[`CFG_RANGE_LSB+1:`CFG_RANGE_LSB];
  // Fixed detectors are always analog
  assign analog_sel = {4'hf, dual_analog};
  // A dual channel turned analog releases its logic input
  assign o_logic_input_en = ~dual_analog;
  assign o_irq = |(irq_stat & irq_mask);

  always @* begin
    addr_ok = chan_space | (paddr == `ADDR_STATUS) |
      (paddr == `ADDR_IRQ_STAT) | (paddr == `ADDR_IRQ_MASK);
    rdata = 32'h0;
    if (chan_space) begin
      case (sub)
        `OFF_CFG: begin
          rdata[`CFG_MODE_LSB+1:`CFG_MODE_LSB] = cfg_mode[ch];
          rdata[`CFG_RANGE_LSB+1:`CFG_RANGE_LSB] = cfg_range[ch];
          rdata[`CFG_ANALOG_BIT] = analog_sel[ch];
          rdata[`CFG_HYST_LSB+4:`CFG_HYST_LSB] = cfg_hyst[ch];
        end
        `OFF_UVTH: rdata[7:0] = uvth[ch];
        `OFF_OVTH: rdata[7:0] = ovth[ch];
        default: rdata[6:0] = filt_us[ch];
      endcase
    end else if (paddr == `ADDR_STATUS) begin
      rdata[7:0] = fault_vec;
    end else if (paddr == `ADDR_IRQ_STAT) begin
      rdata[7:0] = irq_stat;
    end else if (paddr == `ADDR_IRQ_MASK) begin
      rdata[7:0] = irq_mask;
    end
  end

  // Range codes a channel cannot reach fall back to one it can
  always @* begin
    next_range = wr_range;
    if (ch == `CH_HV) begin
      // Only the two upper ranges exist on the high input
      next_range = {1'b1, wr_range[0]};
    end else if (ch >= `CH_VP_LO) begin
      if (wr_range == `RANGE_TOP) begin
        next_range = `RANGE_HI;
      end
    end else begin
      next_range = `RANGE_LOW;
    end
  end

  // Clamp to the longest supported timeout
  always @* begin
    if (pwdata[6:0] > `FILT_MAX_US) begin
      next_filt = `FILT_MAX_US;
    end else begin
      next_filt = pwdata[6:0];
    end
  end

  // New events win over a same-cycle write-one-to-clear
  always @* begin
    next_irq_stat = irq_stat | event_vec;
    if (wr_stat) begin
      next_irq_stat = (irq_stat & ~pwdata[7:0]) | event_vec;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat <= 8'h00;
      irq_mask <= 8'h00;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_mask) begin
        irq_mask <= pwdata[7:0];
      end
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (k = 0; k < `NUM_CH; k = k + 1) begin
        cfg_mode[k] <= `MODE_OFF;
        cfg_range[k] <= `RANGE_LOW;
        cfg_hyst[k] <= 5'h00;
        uvth[k] <= 8'h00;
        ovth[k] <= 8'h00;
        filt_us[k] <= 7'h00;
      end
      cfg_range[`CH_HV] <= `RANGE_HI;
      dual_analog <= 4'h0;
    end else begin
      if (wr_cfg) begin
        cfg_mode[ch] <= pwdata[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
        cfg_hyst[ch] <= pwdata[`CFG_HYST_LSB+4:`CFG_HYST_LSB];
        cfg_range[ch] <= next_range;
        if (ch < `CH_VP_LO) begin
          dual_analog[ch[1:0]] <= pwdata[`CFG_ANALOG_BIT];
        end
      end
      if (wr_uvth) begin
        uvth[ch] <= pwdata[7:0];
      end
      if (wr_ovth) begin
        ovth[ch] <= pwdata[7:0];
      end
      if (wr_filt) begin
        filt_us[ch] <= next_filt;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : g_ch
      reg uv_s1;
      reg uv_s2;
      reg ov_s1;
      reg ov_s2;
      reg uv_raw;
      reg ov_raw;
      reg filt_out;
      reg filt_d;
      reg [13:0] cnt;
      reg [7:0] uv_ref;
      reg [7:0] ov_ref;
      reg [7:0] next_uv_ref;
      reg [7:0] next_ov_ref;
      wire en_uv;
      wire en_ov;
      wire raw;
      wire [8:0] uv_sum;
      wire [8:0] ov_dif;
      wire [13:0] tmo;

      // Range codes map onto the bottom/span table of the analog side
      assign o_range_sel[2*gi+1:2*gi] = cfg_range[gi];
      assign en_uv = analog_sel[gi] & cfg_mode[gi][0];
      assign en_ov = analog_sel[gi] & cfg_mode[gi][1];
      // Hysteresis shares the threshold's code scale, so it adds directly
      assign uv_sum = {1'b0, uvth[gi]} + {4'h0, cfg_hyst[gi]};
      assign ov_dif = {1'b0, ovth[gi]} - {4'h0, cfg_hyst[gi]};
      assign raw = uv_raw | ov_raw;
      assign tmo = {7'h00, filt_us[gi]} * `CYC_PER_US;
      assign o_uv_ref[8*gi+7:8*gi] = uv_ref;
      assign o_ov_ref[8*gi+7:8*gi] = ov_ref;
      assign fault_vec[gi] = filt_out;
      assign o_fault[gi] = filt_out;
      assign event_vec[gi] = filt_out & ~filt_d;

      // Two flops per comparator before any logic reads it
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          uv_s1 <= 1'b0;
          uv_s2 <= 1'b0;
          ov_s1 <= 1'b0;
          ov_s2 <= 1'b0;
        end else begin
          uv_s1 <= i_uv_below[gi];
          uv_s2 <= uv_s1;
          ov_s1 <= i_ov_above[gi];
          ov_s2 <= ov_s1;
        end
      end

      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          uv_raw <= 1'b0;
          ov_raw <= 1'b0;
        end else begin
          uv_raw <= uv_s2 & en_uv;
          ov_raw <= ov_s2 & en_ov;
        end
      end

      // Hysteresis only shifts a reference while its fault stands
      always @* begin
        next_uv_ref = uvth[gi];
        if (uv_raw && uv_sum[8]) begin
          next_uv_ref = `CODE_MAX;
        end else if (uv_raw) begin
          next_uv_ref = uv_sum[7:0];
        end
        next_ov_ref = ovth[gi];
        if (ov_raw && ov_dif[8]) begin
          next_ov_ref = 8'h00;
        end else if (ov_raw) begin
          next_ov_ref = ov_dif[7:0];
        end
      end

      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          uv_ref <= 8'h00;
          ov_ref <= `CODE_MAX;
        end else begin
          uv_ref <= next_uv_ref;
          ov_ref <= next_ov_ref;
        end
      end

      // Output follows only after the input held its new level
      always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          filt_out <= 1'b0;
          filt_d <= 1'b0;
          cnt <= 14'h0000;
        end else begin
          filt_d <= filt_out;
          if (raw == filt_out) begin
            cnt <= 14'h0000;
          end else if (cnt >= tmo) begin
            filt_out <= raw;
            cnt <= 14'h0000;
          end else begin
            cnt <= cnt + 14'h0001;
          end
        end
      end
    end
  endgenerate

endmodule

// ### tb/sfd_rail_model.sv
// Comparator pair model standing in for the analog rail front end.
`timescale 1ns/10ps
module sfd_rail_model (
  input wire logic [63:0] i_rail, // Rail level per channel, code steps
  input wire logic [63:0] i_uv_ref, // Undervoltage reference codes
  input wire logic [63:0] i_ov_ref, // Overvoltage reference codes
  output logic [7:0] o_below, // Rail below its uv reference
  output logic [7:0] o_above // Rail above its ov reference
);
  // Comparators never stop, so a moved reference shows at once
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_below[k] = i_rail[8*k+:8] < i_uv_ref[8*k+:8];
      o_above[k] = i_rail[8*k+:8] > i_ov_ref[8*k+:8];
    end
  end
endmodule

// ### tb/sfd_properties.sv
// Port-level checks of the supply fault detector.
`timescale 1ns/10ps
module sfd_properties (
  input wire logic i_clk, // Clock
  input wire logic i_arst_n, // Reset, active low
  input wire logic [7:0] i_uv_below, // Undervoltage comparators
  input wire logic [7:0] i_ov_above, // Overvoltage comparators
  input wire logic [15:0] o_range_sel, // Range codes
  input wire logic [7:0] o_fault, // Filtered faults
  input wire logic o_irq // Interrupt
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_dual_rng; o_range_sel[7:0] == 8'h00; endproperty
  a_dual_rng: assert property (p_dual_rng)
    else $error("dual channel range moved");
  property p_hv_rng; o_range_sel[15]; endproperty
  a_hv_rng: assert property (p_hv_rng)
    else $error("high voltage range below 2.5 V");
  property p_vp_rng;
    o_range_sel[9:8] != 2'h3 && o_range_sel[11:10] != 2'h3 &&
    o_range_sel[13:12] != 2'h3;
  endproperty
  a_vp_rng: assert property (p_vp_rng)
    else $error("positive channel on top range");
  // Three edges: two sync flops and the raw flop ahead of the filter
  property p_uv_rise; $rose(o_fault[4]) |-> $past(i_uv_below[4], 3);
  endproperty
  a_uv_rise: assert property (p_uv_rise)
    else $error("uv fault without low rail");
  property p_uv_fall; $fell(o_fault[4]) |-> !$past(i_uv_below[4], 3);
  endproperty
  a_uv_fall: assert property (p_uv_fall)
    else $error("uv fault cleared while rail low");
  property p_ov_rise; $rose(o_fault[5]) |-> $past(i_ov_above[5], 3);
  endproperty
  a_ov_rise: assert property (p_ov_rise)
    else $error("ov fault without high rail");
  property p_ov_fall; $fell(o_fault[5]) |-> !$past(i_ov_above[5], 3);
  endproperty
  a_ov_fall: assert property (p_ov_fall)
    else $error("ov fault cleared while rail high");
  property p_flt_rise; $rose(o_fault[6]) |-> $past(i_uv_below[6], 3);
  endproperty
  a_flt_rise: assert property (p_flt_rise)
    else $error("filtered fault without cause");
  c_irq: cover property ($rose(o_irq));
  c_flt: cover property ($rose(o_fault[6]));
  c_ov: cover property ($fell(o_fault[5]));
endmodule

// ### tb/tb_supply_fault_detector.sv
// Register-level regression of the supply fault detector.
`timescale 1ns/10ps
`include "sfd_consts.vh"
module tb_supply_fault_detector;
  logic i_clk, i_arst_n, psel, penable, pwrite, pready, pslverr, o_irq, e;
  logic [7:0] paddr, i_uv_below, i_ov_above, o_fault;
  logic [31:0] pwdata, prdata, q;
  logic [63:0] o_uv_ref, o_ov_ref, rail;
  logic [15:0] o_range_sel;
  logic [3:0] o_logic_input_en;
  int bad_count, n_compared;
  supply_fault_detector u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_uv_below(i_uv_below), .i_ov_above(i_ov_above), .o_uv_ref(o_uv_ref),
    .o_ov_ref(o_ov_ref), .o_range_sel(o_range_sel), .o_fault(o_fault),
    .o_logic_input_en(o_logic_input_en), .o_irq(o_irq));
  sfd_rail_model u_rails (.i_rail(rail), .i_uv_ref(o_uv_ref),
    .i_ov_ref(o_ov_ref), .o_below(i_uv_below), .o_above(i_ov_above));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task give_verdict;
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask
  // Called right after a rising edge; one idle edge keeps drives apart
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk) penable <= 1'b1;
    n = 0;
    do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge i_clk);
    if (n >= 20) begin bad_count++; give_verdict; end
  endtask
  task wait_f(input int k, input logic v, input string s);
    int n;
    n = 0;
    while (o_fault[k] !== v && n < 8) begin @(posedge i_clk); n++; end
    @(posedge i_clk);
    chk(s, {31'h0, v}, {31'h0, o_fault[k]});
    if (o_fault[k] !== v) give_verdict;
  endtask
  initial begin
    i_arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; rail = {8{8'h80}};
    bad_count = 0; n_compared = 0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    chk("range", 32'h8000, o_range_sel);
    chk("logic_en", 32'hf, o_logic_input_en);
    xfer(1'b1, 8'h70, 32'hc);
    xfer(1'b1, 8'h40, 32'hc);
    xfer(1'b1, 8'h00, 32'h18);
    chk("range", 32'hc200, o_range_sel);
    chk("logic_en", 32'he, o_logic_input_en);
    for (int k = 1; k < 4; k++) xfer(1'b1, 8'(k * 16), 32'h10);
    chk("logic_en", 32'h0, o_logic_input_en);
    $display("ranges done");
    xfer(1'b1, 8'h44, 32'h40);
    xfer(1'b1, 8'h40, 32'h501);
    xfer(1'b1, `ADDR_IRQ_MASK, 32'h10);
    rail[39:32] <= 8'h30;
    wait_f(4, 1'b1, "uv_fault");
    chk("uv_ref", 32'h45, o_uv_ref[39:32]);
    chk("irq", 32'h1, o_irq);
    xfer(1'b0, `ADDR_STATUS, 32'h0);
    chk("status", 32'h10, q);
    xfer(1'b1, `ADDR_IRQ_STAT, 32'h10);
    chk("irq", 32'h0, o_irq);
    rail[39:32] <= 8'h44;
    repeat (20) @(posedge i_clk);
    chk("uv_hold", 32'h10, o_fault & 8'h10);
    rail[39:32] <= 8'h46;
    wait_f(4, 1'b0, "uv_clear");
    $display("undervoltage done");
    xfer(1'b1, 8'h58, 32'h80);
    xfer(1'b1, 8'h50, 32'h402);
    rail[47:40] <= 8'h90;
    wait_f(5, 1'b1, "ov_fault");
    chk("ov_ref", 32'h7c, o_ov_ref[47:40]);
    rail[47:40] <= 8'h7e;
    repeat (20) @(posedge i_clk);
    chk("ov_hold", 32'h20, o_fault & 8'h20);
    rail[47:40] <= 8'h70;
    wait_f(5, 1'b0, "ov_clear");
    $display("overvoltage done");
    xfer(1'b1, 8'h6c, 32'hff);
    xfer(1'b0, 8'h6c, 32'h0);
    chk("filt", 32'h64, q);
    xfer(1'b1, 8'h6c, 32'h1);
    xfer(1'b1, 8'h64, 32'h40);
    xfer(1'b1, 8'h60, 32'h1);
    rail[55:48] <= 8'h30;
    repeat (50) @(posedge i_clk);
    chk("glitch", 32'h0, o_fault & 8'h40);
    rail[55:48] <= 8'h80;
    repeat (150) @(posedge i_clk);
    chk("glitch", 32'h0, o_fault & 8'h40);
    rail[55:48] <= 8'h30;
    repeat (100) @(posedge i_clk);
    chk("delay", 32'h0, o_fault & 8'h40);
    repeat (10) @(posedge i_clk);
    chk("delay", 32'h40, o_fault & 8'h40);
    $display("filter done");
    xfer(1'b1, 8'h74, 32'h40);
    xfer(1'b1, 8'h78, 32'hc0);
    xfer(1'b1, 8'h70, 32'hf);
    repeat (8) @(posedge i_clk);
    chk("win_in", 32'h0, o_fault & 8'h80);
    rail[63:56] <= 8'h30;
    wait_f(7, 1'b1, "win_low");
    rail[63:56] <= 8'h80;
    wait_f(7, 1'b0, "win_low_clear");
    rail[63:56] <= 8'hd0;
    wait_f(7, 1'b1, "win_high");
    $display("window done");
    xfer(1'b0, 8'h90, 32'h0);
    chk("slverr", 32'h1, e);
    chk("unmapped", 32'h0, q);
    $display("unmapped done");
    give_verdict;
  end
endmodule
bind supply_fault_detector sfd_properties u_props (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_uv_below(i_uv_below), .i_ov_above(i_ov_above),
  .o_range_sel(o_range_sel), .o_fault(o_fault), .o_irq(o_irq));
